// *** rtl/vc0_res_defs.vh ***
`ifndef VC0_RES_DEFS_VH
`define VC0_RES_DEFS_VH
// Summary of operation
// - the capability word reports supported port arbitration schemes in bits 7:0 as fixed 03h.
// - hardware fixed round robin and weighted round robin with 128 phases are supported.
// - time-based weighted round robin is never offered on this default channel.
// - capability bits 22:16 read the maximum time slots minus one, fixed 3Fh.
// - capability bits 31:24 read the arbitration table location in sixteen_byte_unit steps, fixed 05h.
// - capability bit 14 reads zero, the resource is not limited to packet-switching traffic.
// - control bits 7:0 hold a writable traffic_class_channel_map resetting to FFh.
// - map bit 0 always reads one and ignores writes.
// - writing one to control bit 16 applies the table to the arbiters and the bit reads zero.
// - scheme select bits 19:17 accept only 000b or 011b, other writes store the default.
// - control bits 26:24 read the channel identifier 000b.
// - control bit 31 is a writable enable that resets to one.
// - the table status flag sets on any table entry write and clears when a load finishes, unless an entry write lands in that same cycle.

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define ADDR_RES_CAP      12'h158
`define ADDR_RES_CTRL     12'h15C
`define ADDR_RES_STATUS   12'h160
// ----------------------------------------
// capability fields
// ----------------------------------------
`define CAP_ARB_LSB       0
`define CAP_ARB_VAL       8'h03
`define CAP_APS_BIT       14
`define CAP_SLOTS_LSB     16
`define CAP_SLOTS_VAL     7'h3F
`define CAP_TBL_LSB       24
`define CAP_TBL_VAL       8'h05
// ----------------------------------------
// control fields
// ----------------------------------------
`define CTL_MAP_LSB       0
`define CTL_MAP_RST       8'hFF
`define CTL_LOAD_BIT      16
`define CTL_SEL_LSB       17
`define CTL_SEL_DEF       3'h0
`define CTL_SEL_WRR       3'h3
`define CTL_ID_LSB        24
`define CTL_ID_VAL        3'h0
`define CTL_EN_BIT        31
// ----------------------------------------
// status fields and timing
// ----------------------------------------
`define STS_TBL_BIT       16
`define LOAD_CYCLES       8'h04
`endif

// *** rtl/vc0_table_loader.v ***
`include "vc0_res_defs.vh"
module vc0_table_loader #(
	parameter CYCLES = `LOAD_CYCLES
) (
	input  wire clk,
	input  wire rst,
	input  wire start,
	output reg  busy_r,
	output reg  done_r
);
	reg [7:0] cnt_r;
	// ----------------------------------------
	// copy sequencer
	// ----------------------------------------
	// a load request during a copy restarts it so the newest table wins
	always @(posedge clk) begin
		if (rst) begin
			busy_r <= 1'b0;
			done_r <= 1'b0;
			cnt_r  <= 8'h00;
		end else begin
			done_r <= 1'b0;
			if (start) begin
				busy_r <= 1'b1;
				cnt_r  <= CYCLES - 8'h01;
			end else if (busy_r) begin
				if (cnt_r == 8'h00) begin
					busy_r <= 1'b0;
					done_r <= 1'b1;
				end else begin
					cnt_r <= cnt_r - 8'h01;
				end
			end
		end
	end
endmodule

// *** rtl/vc0_resource_registers.v ***
`include "vc0_res_defs.vh"
module vc0_resource_registers (
	input  wire        REF_CLK,
	input  wire        RST,
	input  wire        HSEL,
	input  wire [11:0] HADDR,
	input  wire [1:0]  HTRANS,
	input  wire        HWRITE,
	input  wire [2:0]  HSIZE,
	input  wire [31:0] HWDATA,
	input  wire        HREADY,
	output reg  [31:0] HRDATA,
	output reg         HREADYOUT,
	output reg         HRESP,
	input  wire        TABLE_ENTRY_WR,
	output reg  [7:0]  TC_MAP,
	output reg  [2:0]  ARB_SELECT,
	output reg         VC_ENABLE,
	output reg         TABLE_LOAD,
	output reg         TABLE_BUSY
);
	// ----------------------------------------
	// local constants
	// ----------------------------------------
	localparam       MAP_W   = 8;
	localparam       SEL_W   = 3;
	localparam       HIT_CAP = 0;
	localparam       HIT_CTL = 1;
	localparam       HIT_STS = 2;
	localparam [7:0] MAP_RST = `CTL_MAP_RST;

	// ----------------------------------------
	// state
	// ----------------------------------------
	reg              wr_pend_r;
	reg              wr_ctl_r;
	reg  [SEL_W-1:0] sel_r;
	reg              en_r;
	reg              tbl_flag_r;
	reg              load_r;
	reg              entry_s1_r;
	reg              entry_s2_r;
	reg  [31:0]      rdata_nxt;
	reg              flag_nxt;
	wire             ld_busy;
	wire             ld_done;
	wire             addr_ph;
	wire             rd_req;
	wire             wr_req;
	wire [2:0]       ad_hit;
	wire             ctl_wr;
	wire [MAP_W-1:1] wr_map;
	wire [SEL_W-1:0] wr_sel;
	wire             wr_load;
	wire             wr_en;
	wire [MAP_W-1:0] map_bits;
	wire [31:0]      cap_word;
	wire [31:0]      ctl_word;
	wire [31:0]      sts_word;

	// ----------------------------------------
	// decode functions
	// ----------------------------------------
	// fixed scheme validation; anything but the two legal codes falls back to default
	function [2:0] legal_sel;
		input [2:0] v;
		begin
			if (v == `CTL_SEL_WRR)
				legal_sel = `CTL_SEL_WRR;
			else
				legal_sel = `CTL_SEL_DEF;
		end
	endfunction

	// one-hot register select, shared by the read path and the write pipeline
	function [2:0] reg_hit;
		input [11:0] a;
		reg   [11:0] w;
		begin
			w       = {a[11:2], 2'h0};
			reg_hit = 3'h0;
			if (w == `ADDR_RES_CAP)
				reg_hit = 3'h1;
			else if (w == `ADDR_RES_CTRL)
				reg_hit = 3'h2;
			else if (w == `ADDR_RES_STATUS)
				reg_hit = 3'h4;
		end
	endfunction

	// ----------------------------------------
	// write data fields
	// ----------------------------------------
	// map bit 0 has no storage, so it is not taken from the bus at all
	assign wr_map  = HWDATA[`CTL_MAP_LSB + MAP_W - 1 : `CTL_MAP_LSB + 1];
	assign wr_load = HWDATA[`CTL_LOAD_BIT];
	assign wr_sel  = HWDATA[`CTL_SEL_LSB +: SEL_W];
	assign wr_en   = HWDATA[`CTL_EN_BIT];

	// ----------------------------------------
	// read words
	// ----------------------------------------
	// only fixed and weighted round robin are reported; the time-based scheme bit stays clear
	assign cap_word[`CAP_ARB_LSB +: 8]   = `CAP_ARB_VAL;
	assign cap_word[13:8]                = 6'h00;
	assign cap_word[`CAP_APS_BIT]        = 1'b0;
	assign cap_word[15]                  = 1'b0;
	assign cap_word[`CAP_SLOTS_LSB +: 7] = `CAP_SLOTS_VAL;
	assign cap_word[23]                  = 1'b0;
	assign cap_word[`CAP_TBL_LSB +: 8]   = `CAP_TBL_VAL;

	// the load strobe is never stored, so its bit always reads zero
	assign ctl_word[`CTL_MAP_LSB +: MAP_W] = map_bits;
	assign ctl_word[15:8]                  = 8'h00;
	assign ctl_word[`CTL_LOAD_BIT]         = 1'b0;
	assign ctl_word[`CTL_SEL_LSB +: SEL_W] = sel_r;
	assign ctl_word[23:20]                 = 4'h0;
	assign ctl_word[`CTL_ID_LSB +: 3]      = `CTL_ID_VAL;
	assign ctl_word[30:27]                 = 4'h0;
	assign ctl_word[`CTL_EN_BIT]           = en_r;

	// negotiation pending is not modelled and reads zero with the reserved bits
	assign sts_word[15:0]         = 16'h0000;
	assign sts_word[`STS_TBL_BIT] = tbl_flag_r;
	assign sts_word[31:17]        = 15'h0000;

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	assign addr_ph = HSEL & HREADY & HTRANS[1];
	assign rd_req  = addr_ph & ~HWRITE;
	assign wr_req  = addr_ph & HWRITE;
	assign ad_hit  = reg_hit(HADDR);
	assign ctl_wr  = wr_pend_r & wr_ctl_r;

	// unmapped addresses read zero
	always @* begin
		rdata_nxt = 32'h00000000;
		if (ad_hit[HIT_CAP])
			rdata_nxt = cap_word;
		else if (ad_hit[HIT_CTL])
			rdata_nxt = ctl_word;
		else if (ad_hit[HIT_STS])
			rdata_nxt = sts_word;
	end

	// a write is taken in its address phase and lands at the end of its data phase
	always @(posedge REF_CLK) begin
		if (RST) begin
			wr_pend_r <= 1'b0;
			wr_ctl_r  <= 1'b0;
		end else begin
			wr_pend_r <= wr_req;
			if (wr_req)
				wr_ctl_r <= ad_hit[HIT_CTL];
		end
	end

	// ----------------------------------------
	// bus response
	// ----------------------------------------
	// read data holds until the next read is taken
	always @(posedge REF_CLK) begin
		if (RST) begin
			HRDATA <= 32'h00000000;
		end else if (rd_req) begin
			HRDATA <= rdata_nxt;
		end
	end

	// zero wait states and an OKAY answer; kept as flops so every output is registered
	always @(posedge REF_CLK) begin
		if (RST) begin
			HREADYOUT <= 1'b1;
			HRESP     <= 1'b0;
		end else begin
			HREADYOUT <= 1'b1;
			HRESP     <= 1'b0;
		end
	end

	// ----------------------------------------
	// traffic class map
	// ----------------------------------------
	// one flop per traffic class; class zero has none and is tied to this channel
	genvar tc;
	generate
		for (tc = 1; tc < MAP_W; tc = tc + 1) begin : g_map
			reg tc_r;
			always @(posedge REF_CLK) begin
				if (RST)
					tc_r <= MAP_RST[tc];
				else if (ctl_wr)
					tc_r <= wr_map[tc];
			end
			assign map_bits[tc] = tc_r;
		end
	endgenerate
	assign map_bits[0] = 1'b1;

	// ----------------------------------------
	// control register
	// ----------------------------------------
	always @(posedge REF_CLK) begin
		if (RST) begin
			sel_r  <= `CTL_SEL_DEF;
			en_r   <= 1'b1;
			load_r <= 1'b0;
		end else begin
			load_r <= 1'b0;
			if (ctl_wr) begin
				sel_r  <= legal_sel(wr_sel);
				en_r   <= wr_en;
				load_r <= wr_load;
			end
		end
	end

	// ----------------------------------------
	// table load sequencer
	// ----------------------------------------
	vc0_table_loader #(
		.CYCLES (`LOAD_CYCLES)
	) u_loader (
		.clk    (REF_CLK),
		.rst    (RST),
		.start  (load_r),
		.busy_r (ld_busy),
		.done_r (ld_done)
	);

	// ----------------------------------------
	// entry strobe synchroniser
	// ----------------------------------------
	// the strobe comes from the table storage, which may sit on another clock;
	// a single short pulse there can be missed, so it must stand for two of our cycles
	always @(posedge REF_CLK) begin
		if (RST) begin
			entry_s1_r <= 1'b0;
			entry_s2_r <= 1'b0;
		end else begin
			entry_s1_r <= TABLE_ENTRY_WR;
			entry_s2_r <= entry_s1_r;
		end
	end

	// ----------------------------------------
	// table status flag
	// ----------------------------------------
	// a table write in the cycle a load finishes keeps the flag set: set wins over clear
	always @* begin
		flag_nxt = tbl_flag_r;
		if (entry_s2_r)
			flag_nxt = 1'b1;
		else if (ld_done)
			flag_nxt = 1'b0;
	end

	always @(posedge REF_CLK) begin
		if (RST) begin
			tbl_flag_r <= 1'b0;
		end else begin
			tbl_flag_r <= flag_nxt;
		end
	end

	// ----------------------------------------
	// registered outputs
	// ----------------------------------------
	always @(posedge REF_CLK) begin
		if (RST) begin
			TC_MAP <= `CTL_MAP_RST;
		end else begin
			TC_MAP <= map_bits;
		end
	end

	always @(posedge REF_CLK) begin
		if (RST) begin
			ARB_SELECT <= `CTL_SEL_DEF;
		end else begin
			ARB_SELECT <= sel_r;
		end
	end

	always @(posedge REF_CLK) begin
		if (RST) begin
			VC_ENABLE <= 1'b1;
		end else begin
			VC_ENABLE <= en_r;
		end
	end

	always @(posedge REF_CLK) begin
		if (RST) begin
			TABLE_LOAD <= 1'b0;
		end else begin
			TABLE_LOAD <= load_r;
		end
	end

	always @(posedge REF_CLK) begin
		if (RST) begin
			TABLE_BUSY <= 1'b0;
		end else begin
			TABLE_BUSY <= ld_busy;
		end
	end
endmodule

// *** verification/vc0_res_sva.sv ***
module vc0_res_sva (
	input wire        REF_CLK,
	input wire        RST,
	input wire        HSEL,
	input wire [11:0] HADDR,
	input wire [1:0]  HTRANS,
	input wire        HWRITE,
	input wire        HREADY,
	input wire        HREADYOUT,
	input wire        HRESP,
	input wire [31:0] HRDATA,
	input wire [7:0]  TC_MAP,
	input wire [2:0]  ARB_SELECT,
	input wire        VC_ENABLE,
	input wire        TABLE_LOAD,
	input wire        TABLE_BUSY
);
	timeunit 1ns;
	timeprecision 1ps;
	wire rd = HSEL & HREADY & HTRANS[1] & !HWRITE;
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (RST);
	AST_RST_VAL: assert property ($fell(RST) |-> TC_MAP == 8'hFF && VC_ENABLE && ARB_SELECT == 3'h0)
		else $error("reset values wrong");
	AST_MAP0: assert property (TC_MAP[0])
		else $error("map bit 0 low");
	AST_SEL: assert property (ARB_SELECT == 3'h0 || ARB_SELECT == 3'h3)
		else $error("illegal scheme select");
	AST_CAP: assert property (rd && HADDR == 12'h158 |=> HRDATA == 32'h053F0003)
		else $error("capability word wrong");
	AST_CTRL_RSV: assert property (rd && HADDR == 12'h15C |=> (HRDATA & 32'h7FF1FF00) == 32'h0 && HRDATA[0])
		else $error("control reserved bits set");
	AST_LOAD_PULSE: assert property (TABLE_LOAD |=> !TABLE_LOAD)
		else $error("load strobe too long");
	AST_BUSY: assert property (TABLE_LOAD |-> ##[0:2] TABLE_BUSY)
		else $error("load without busy");
	AST_BUSY_LEN: assert property ($rose(TABLE_BUSY) |-> TABLE_BUSY [*4])
		else $error("busy too short");
	AST_BUS_OKAY: assert property (HREADYOUT && !HRESP)
		else $error("bus not ready or error response");
endmodule

bind vc0_resource_registers vc0_res_sva sva_u (.*);

// *** verification/testbench.sv ***
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        ref_clk = 1'b0;
	logic        rst = 1'b1;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic        tbl_wr = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [11:0] haddr = 12'h000;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic [31:0] rd_q;
	logic        hready;
	logic        vc_en;
	logic        tbl_load;
	logic        tbl_busy;
	logic [7:0]  tc_map;
	logic [2:0]  arb_sel;
	int          errors = 0;
	int          num_checks = 0;
	vc0_resource_registers dut_u (.REF_CLK(ref_clk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
		.HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready),
		.HRESP(), .TABLE_ENTRY_WR(tbl_wr), .TC_MAP(tc_map), .ARB_SELECT(arb_sel), .VC_ENABLE(vc_en),
		.TABLE_LOAD(tbl_load), .TABLE_BUSY(tbl_busy));
	initial forever #5 ref_clk = ~ref_clk;
	// ----------------------------------------
	// bus and compare
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("Error %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= wr;
		htrans <= 2'h2;
		do @(posedge ref_clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge ref_clk); while (hready !== 1'b1);
		rd_q = hrdata;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset;
		bus(1'b1, 12'h158, 32'h0);
		bus(1'b0, 12'h158, 32'h0);
		chk(rd_q, 32'h053F0003);
		bus(1'b0, 12'h15C, 32'h0);
		chk(rd_q, 32'h800000FF);
		bus(1'b0, 12'h200, 32'h0);
		chk(rd_q, 32'h0);
	endtask
	task automatic t_map;
		bus(1'b1, 12'h15C, 32'h7FF0FF00);
		repeat (3) @(posedge ref_clk);
		chk({23'h0, vc_en, tc_map}, 32'h1);
		bus(1'b0, 12'h15C, 32'h0);
		chk(rd_q, 32'h1);
	endtask
	task automatic t_sel;
		logic [31:0] e;
		for (int v = 0; v < 8; v++) begin
			e = (v == 0 || v == 3) ? v : 0;
			bus(1'b1, 12'h15C, 32'h800000FF | (v << 17));
			repeat (3) @(posedge ref_clk);
			chk({29'h0, arb_sel}, e);
			bus(1'b0, 12'h15C, 32'h0);
			chk(rd_q, 32'h800000FF | (e << 17));
		end
	endtask
	task automatic t_load;
		// the flag input is synchronised, so it must stand for several cycles
		tbl_wr <= 1'b1;
		repeat (3) @(posedge ref_clk);
		tbl_wr <= 1'b0;
		repeat (3) @(posedge ref_clk);
		bus(1'b0, 12'h160, 32'h0);
		chk(rd_q, 32'h00010000);
		bus(1'b1, 12'h15C, 32'h800100FF);
		for (int i = 0; i < 8 && tbl_load !== 1'b1; i++) @(posedge ref_clk);
		chk({31'h0, tbl_load}, 32'h1);
		bus(1'b0, 12'h15C, 32'h0);
		chk(rd_q, 32'h800000FF);
		chk({31'h0, tbl_busy}, 32'h1);
		repeat (8) @(posedge ref_clk);
		bus(1'b0, 12'h160, 32'h0);
		chk(rd_q, 32'h0);
	endtask
	task automatic wrap_up;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		t_reset;
		t_map;
		t_sel;
		t_load;
		wrap_up;
	end
	initial begin
		#20us;
		errors++;
		wrap_up;
	end
endmodule
